// file: hw/scr_pkg.sv
// Constants, field positions and state encodings of the serial configuration port.
package scr_pkg;

    // Clock rate and the quiet time after a chip soft reset.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RESET_TIME_NS = 750;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 7;

    // Frame layout: one direction bit, a 15-bit address, then data bytes.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CMD_BITS = 16;
    localparam logic [3:0] CMD_LAST_BIT = 4'hf;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

    // Interface configuration register.
    localparam logic [ADDR_W-1:0] INTERFACE_CONFIG_ADDR = 15'h0000;
    localparam logic [DATA_W-1:0] INTERFACE_CONFIG_RESET = 8'h30;
    localparam int SOFT_RESET_BIT = 7;
    localparam int ASCEND_BIT = 5;
    localparam int OUTPUT_INDICATOR_BIT = 4;
    localparam logic [DATA_W-1:0] CONFIG_WRITABLE_MASK = 8'h6f;
    localparam logic [DATA_W-1:0] CONFIG_FIXED_ONES = 8'h10;

    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_CMD = 2'b01,
        SCR_DATA = 2'b10,
        SCR_DRAIN = 2'b11
    } scr_state_type;

endpackage : scr_pkg

// file: hw/scr_addr_step.sv
// Next register address for a streaming transfer.
`timescale 1ns/1ps
module scr_addr_step #(
    parameter int ADDR_W = 15
) (
    // Current address and stepping controls
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ascend,
    input wire logic freeze,
    // Address of the next streamed byte
    output logic [ADDR_W-1:0] addr_next
);

    always_comb begin
        if (freeze) begin
            addr_next = addr;
        end else if (ascend) begin
            addr_next = addr + 1'b1;
        end else begin
            addr_next = addr - 1'b1;
        end
    end

endmodule : scr_addr_step

// file: hw/scr_config_port.sv
// Serial control port with the interface configuration register and chip soft reset.
`timescale 1ns/1ps
module scr_config_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial port pins
    input wire logic spi_csb_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic serial_output_pin,
    output logic serial_output_oe,
    // Access to the rest of the register map
    output logic [scr_pkg::ADDR_W-1:0] reg_addr,
    output logic [scr_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    input wire logic [scr_pkg::DATA_W-1:0] reg_rdata,
    input wire logic addr_freeze,
    // Chip control
    output logic chip_soft_reset,
    output logic addr_ascend
);
    import scr_pkg::*;

    scr_state_type state_r;
    logic sclk_q_r;
    logic [3:0] bit_cnt_r;
    logic [CMD_BITS-1:0] rx_r;
    logic is_read_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic load_r;
    logic [DATA_W-1:0] tx_r;
    logic [DATA_W-1:0] cfg_r;
    logic [HOLD_W-1:0] hold_cnt_r;
    logic hold_r;
    logic sdo_r;
    logic oe_r;
    logic wr_r;
    logic [DATA_W-1:0] wdata_r;

    logic sclk_rise;
    logic sclk_fall;
    logic cmd_done;
    logic byte_done;
    logic [DATA_W-1:0] byte_in;
    logic write_byte;
    logic cfg_write;
    logic soft_req;

    // The serial clock is sampled by clk, so it must stay below a quarter of clk.
    assign sclk_rise = !spi_csb_n && !sclk_q_r && spi_sclk;
    assign sclk_fall = !spi_csb_n && sclk_q_r && !spi_sclk;
    assign cmd_done = sclk_rise && (state_r == SCR_CMD) && (bit_cnt_r == CMD_LAST_BIT);
    assign byte_done = sclk_rise && (state_r == SCR_DATA) && (bit_cnt_r == BYTE_LAST_BIT);
    assign byte_in = {rx_r[DATA_W-2:0], spi_sdi};
    assign write_byte = byte_done && !is_read_r;
    assign cfg_write = write_byte && (addr_r == INTERFACE_CONFIG_ADDR);
    assign soft_req = cfg_write && byte_in[SOFT_RESET_BIT];

    scr_addr_step #(
        .ADDR_W(ADDR_W)
    ) u_addr_step (
        .addr(addr_r),
        .ascend(cfg_r[ASCEND_BIT]),
        .freeze(addr_freeze),
        .addr_next(addr_nxt)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= spi_sclk;
        end
    end

    // Transaction sequencing: command word, then data bytes until chip select rises.
    // A partial command or byte at chip select high is dropped, never applied.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SCR_IDLE;
            bit_cnt_r <= 4'h0;
            rx_r <= 16'h0000;
            is_read_r <= 1'b0;
            addr_r <= 15'h0000;
            load_r <= 1'b0;
        end else begin
            load_r <= 1'b0;
            if (soft_req || hold_r) begin
                // Frames during the quiet time are dropped whole, not half-decoded.
                state_r <= SCR_DRAIN;
                bit_cnt_r <= 4'h0;
                addr_r <= INTERFACE_CONFIG_ADDR;
                is_read_r <= 1'b0;
            end else if (spi_csb_n) begin
                state_r <= SCR_IDLE;
                bit_cnt_r <= 4'h0;
            end else begin
                case (state_r)
                    SCR_IDLE: begin
                        state_r <= SCR_CMD;
                        bit_cnt_r <= 4'h0;
                        if (sclk_rise) begin
                            rx_r <= {rx_r[CMD_BITS-2:0], spi_sdi};
                            bit_cnt_r <= 4'h1;
                        end
                    end
                    SCR_CMD: begin
                        if (sclk_rise) begin
                            rx_r <= {rx_r[CMD_BITS-2:0], spi_sdi};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (cmd_done) begin
                                is_read_r <= rx_r[CMD_BITS-2];
                                addr_r <= {rx_r[ADDR_W-2:0], spi_sdi};
                                state_r <= SCR_DATA;
                                bit_cnt_r <= 4'h0;
                                load_r <= 1'b1;
                            end
                        end
                    end
                    SCR_DATA: begin
                        if (sclk_rise) begin
                            rx_r <= {rx_r[CMD_BITS-2:0], spi_sdi};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (byte_done) begin
                                bit_cnt_r <= 4'h0;
                                addr_r <= addr_nxt;
                                load_r <= 1'b1;
                            end
                        end
                    end
                    SCR_DRAIN: begin
                        state_r <= SCR_DRAIN;
                    end
                    default: begin
                        state_r <= SCR_IDLE;
                    end
                endcase
            end
        end
    end

    // Configuration register; the request bit is never stored, so it reads as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= INTERFACE_CONFIG_RESET;
        end else if (soft_req) begin
            cfg_r <= INTERFACE_CONFIG_RESET;
        end else if (cfg_write) begin
            // Reserved bits are stored as written; the host is expected to keep them zero.
            cfg_r <= (byte_in & CONFIG_WRITABLE_MASK) | CONFIG_FIXED_ONES;
        end
    end

    // Chip reset pulse, held for the whole quiet time.
    // The count is a package constant, so a faster clock needs a longer count there.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= 7'h00;
            hold_r <= 1'b0;
        end else if (soft_req) begin
            hold_cnt_r <= HOLD_W'(SOFT_RESET_CYCLES - 1);
            hold_r <= 1'b1;
        end else if (hold_cnt_r != 7'h00) begin
            hold_cnt_r <= hold_cnt_r - 7'h01;
        end else begin
            hold_r <= 1'b0;
        end
    end

    // Writes to the rest of the map leave as a one-cycle strobe.
    // Receivers must take the data on the strobe, since the data word may change later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
            wdata_r <= 8'h00;
        end else begin
            wr_r <= write_byte && (addr_r != INTERFACE_CONFIG_ADDR) && !hold_r;
            if (write_byte) begin
                wdata_r <= byte_in;
            end
        end
    end

    // Read data shift out on falling edges, on the dedicated output pin only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 8'h00;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (spi_csb_n || hold_r || soft_req) begin
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (load_r) begin
            // One cycle after the address moves, so outside read data has settled.
            tx_r <= (addr_r == INTERFACE_CONFIG_ADDR) ? cfg_r : reg_rdata;
            oe_r <= is_read_r;
        end else if (sclk_fall && is_read_r && (state_r == SCR_DATA)) begin
            sdo_r <= tx_r[DATA_W-1];
            tx_r <= {tx_r[DATA_W-2:0], 1'b0};
        end
    end

    assign serial_output_pin = sdo_r;
    assign serial_output_oe = oe_r;
    assign reg_addr = addr_r;
    assign reg_wdata = wdata_r;
    assign reg_wr = wr_r;
    assign chip_soft_reset = hold_r;
    assign addr_ascend = cfg_r[ASCEND_BIT];

endmodule : scr_config_port

// file: dv/scr_config_port_assertions.sv
// Checker for the configuration port, watching its top-level ports.
`timescale 1ns/1ps
module scr_config_port_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Observed ports
    input wire logic spi_csb_n,
    input wire logic serial_output_pin,
    input wire logic serial_output_oe,
    input wire logic [scr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic addr_freeze,
    input wire logic chip_soft_reset,
    input wire logic addr_ascend
);
    logic [7:0] held_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_r <= 8'h00;
        end else begin
            held_r <= chip_soft_reset ? held_r + 8'h01 : 8'h00;
        end
    end
    a_reset_len_exact: assert property ($fell(chip_soft_reset)
        |-> held_r == 8'(scr_pkg::SOFT_RESET_CYCLES))
        else $error("soft reset length wrong");
    a_reset_self_clear: assert property (held_r == 8'(scr_pkg::SOFT_RESET_CYCLES)
        |-> !chip_soft_reset)
        else $error("soft reset never clears");
    a_reset_cfg_value: assert property (chip_soft_reset |-> addr_ascend && !serial_output_oe)
        else $error("config not reset");
    a_addr_step_dir: assert property (!spi_csb_n && serial_output_oe && $past(serial_output_oe)
        && $changed(reg_addr) |-> reg_addr == (addr_ascend ? $past(reg_addr) + 15'h0001
        : $past(reg_addr) - 15'h0001))
        else $error("address step wrong");
    a_addr_freeze_hold: assert property (!spi_csb_n && serial_output_oe && $past(serial_output_oe)
        && addr_freeze |-> $stable(reg_addr))
        else $error("frozen address moved");
    a_output_in_frame: assert property (serial_output_oe |-> !$past(spi_csb_n))
        else $error("output enabled outside frame");
    a_rst_cfg_value: assert property ($rose(rst_n) |-> addr_ascend && !chip_soft_reset)
        else $error("reset value wrong");
endmodule : scr_config_port_assertions

// file: dv/scr_host_model.sv
// Host serial controller that frames commands and bytes for the port.
`timescale 1ns/1ps
module scr_host_model (
    // Clock
    input wire logic clk,
    // Serial port pins
    output logic spi_csb_n,
    output logic spi_sclk,
    output logic spi_sdi,
    input wire logic serial_output_pin
);
    initial begin
        spi_csb_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end
    task automatic xfer(input logic [15:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] bits;
        bits = {cmd, (cmd[14:0] == 15'h0000) ? (wd & 8'hb0) : wd};
        @(posedge clk);
        #1 spi_csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_sdi = bits[i];
            repeat (3) @(posedge clk);
            rd = {rd[6:0], serial_output_pin};
            #1 spi_sclk = 1'b1;
            repeat (3) @(posedge clk);
            #1;
        end
        // The device may still be resetting, so nothing is started meanwhile.
        if (bits[23:7] == 17'h00001) repeat (80) @(posedge clk);
    endtask : xfer
    task automatic stop();
        spi_csb_n = 1'b1;
        spi_sdi = ~spi_sdi;
        spi_sclk = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : stop
endmodule : scr_host_model

// file: dv/testbench.sv
// Self-checking bench for the serial configuration port.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
    typedef struct {logic [15:0] c; logic [7:0] w; logic f; logic [7:0] r; logic [14:0] a;} scr_row_type;
    logic clk, rst_n, spi_csb_n, spi_sclk, spi_sdi, serial_output_pin, serial_output_oe;
    logic reg_wr, addr_freeze, chip_soft_reset, addr_ascend;
    logic [14:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    int total_checks, miscompares, cycles, soft_cycles, wr_count;
    scr_row_type rows [6] = '{'{16'h8000, 8'h00, 1'b0, 8'h30, 15'h0001},
        '{16'h0000, 8'h00, 1'b0, 8'h00, 15'h0000}, '{16'h8000, 8'h00, 1'b0, 8'h10, 15'h7fff},
        '{16'h0000, 8'h7f, 1'b0, 8'h00, 15'h0000}, '{16'h8005, 8'h00, 1'b1, 8'ha0, 15'h0005},
        '{16'h8005, 8'h00, 1'b0, 8'ha0, 15'h0006}};
    assign reg_rdata = reg_addr[7:0] ^ 8'ha5;
    scr_config_port scr_config_port_i (.clk, .rst_n, .spi_csb_n, .spi_sclk, .spi_sdi,
        .serial_output_pin, .serial_output_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
        .addr_freeze, .chip_soft_reset, .addr_ascend);
    scr_host_model scr_host_model_i (.clk, .spi_csb_n, .spi_sclk, .spi_sdi, .serial_output_pin);
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (chip_soft_reset === 1'b1) soft_cycles++;
        if (reg_wr === 1'b1) wr_count++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        addr_freeze = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        `CHK("ascend", 1'b1, addr_ascend)
        foreach (rows[i]) begin
            addr_freeze = rows[i].f;
            scr_host_model_i.xfer(rows[i].c, rows[i].w, rd);
            if (rows[i].c[15]) begin
                `CHK("read data", rows[i].r, rd)
                `CHK("address", rows[i].a, reg_addr)
            end
            scr_host_model_i.stop();
        end
        scr_host_model_i.xfer(16'h0000, 8'h00, rd);
        scr_host_model_i.stop();
        `CHK("ascend", 1'b0, addr_ascend)
        scr_host_model_i.xfer(16'h0000, 8'h80, rd);
        `CHK("soft reset", 1'b0, chip_soft_reset)
        `CHK("ascend", 1'b1, addr_ascend)
        scr_host_model_i.stop();
        scr_host_model_i.xfer(16'h8000, 8'h00, rd);
        `CHK("config", 8'h30, rd)
        scr_host_model_i.stop();
        `CHK("soft reset length", scr_pkg::SOFT_RESET_CYCLES, soft_cycles)
        scr_host_model_i.xfer(16'h0000, 8'h00, rd);
        scr_host_model_i.stop();
        scr_host_model_i.xfer(16'h0012, 8'h5a, rd);
        `CHK("address", 15'h0011, reg_addr)
        scr_host_model_i.stop();
        `CHK("write data", 8'h5a, reg_wdata)
        `CHK("write strobes", 1, wr_count)
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        `CHK("ascend", 1'b1, addr_ascend)
        scr_host_model_i.xfer(16'h8000, 8'h00, rd);
        `CHK("config", 8'h30, rd)
        `CHK("address", 15'h0001, reg_addr)
        scr_host_model_i.stop();
        end_of_test();
    end
endmodule : testbench
bind scr_config_port scr_config_port_assertions scr_config_port_assertions_i (.clk, .rst_n,
    .spi_csb_n, .serial_output_pin, .serial_output_oe, .reg_addr, .addr_freeze,
    .chip_soft_reset, .addr_ascend);
